// ---- design/dma_engine.sv ----
`timescale 1ns/1ps
`default_nettype none
module dma_engine #(
  parameter int NUM_CH = 16,
  parameter int PW     = 4,
  parameter int CW     = $clog2(NUM_CH)
) (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_sys_rst,
  // Requests and configuration
  input  wire logic [NUM_CH-1:0]    i_req,
  input  wire logic                 i_arb_rr,
  input  wire logic [NUM_CH*PW-1:0] i_prio,
  input  wire logic [NUM_CH-1:0]    i_sg_en,
  input  wire logic [NUM_CH-1:0]    i_link_minor_en,
  input  wire logic [NUM_CH*CW-1:0] i_link_minor_ch,
  input  wire logic [NUM_CH-1:0]    i_link_major_en,
  input  wire logic [NUM_CH*CW-1:0] i_link_major_ch,
  // Descriptor write port
  input  wire logic                 i_desc_wr,
  input  wire logic [CW-1:0]        i_desc_ch,
  input  wire logic [2:0]           i_desc_idx,
  input  wire logic [31:0]          i_desc_data,
  // Bus master
  output logic                      o_bus_req,
  output logic                      o_bus_we,
  output logic [31:0]               o_bus_addr,
  output logic [1:0]                o_bus_size,
  output logic [31:0]               o_bus_wdata,
  input  wire logic                 i_bus_ack,
  input  wire logic [31:0]          i_bus_rdata,
  // Status
  output logic [NUM_CH-1:0]         o_done,
  output logic [NUM_CH-1:0]         o_irq_major,
  output logic [NUM_CH-1:0]         o_irq_half,
  output logic                      o_busy,
  output logic [CW-1:0]             o_active_ch
);
  import dma_pkg::*;

  // Bytes per element for a size code
  function automatic logic [31:0] size_bytes(input logic [1:0] code);
    case (code)
      SZ_8:    size_bytes = 32'h1;
      SZ_16:   size_bytes = 32'h2;
      SZ_32:   size_bytes = 32'h4;
      default: size_bytes = 32'h10;
    endcase
  endfunction : size_bytes

  // Offset step with optional modulo window
  function automatic logic [31:0] step(input logic [31:0] a, input logic [31:0] off,
                                       input logic [3:0] md);
    logic [31:0] sum;
    logic [31:0] mask;
    sum = a + off;
    mask = (md == 4'h0) ? 32'hffffffff : ((32'h1 << md) - 32'h1);
    step = (a & ~mask) | (sum & mask);
  endfunction : step

  logic [31:0]      desc_reg [NUM_CH][DESC_WORDS];
  logic [31:0]      desc_next [NUM_CH][DESC_WORDS];
  logic [MAJ_W-1:0] major_count_current_reg [NUM_CH];
  logic [MAJ_W-1:0] major_count_current_next [NUM_CH];
  logic [NUM_CH-1:0] pend_reg, pend_next, done_reg, done_next;
  logic [NUM_CH-1:0] irqm_reg, irqm_next, irqh_reg, irqh_next;
  state_t      state_reg, state_next, ret_reg, ret_next;
  logic [CW-1:0] ch_reg, ch_next, last_reg, last_next;
  logic [2:0]  beat_reg, beat_next;
  logic [31:0] left_reg, left_next;
  logic [3:0]  stall_reg, stall_next;
  logic        req_reg, req_next, we_reg, we_next;
  logic [31:0] addr_reg, addr_next, wdata_reg, wdata_next;
  logic [1:0]  size_reg, size_next;
  logic        busy_reg, busy_next;
  // FIFO hookup
  logic        f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [31:0] f_out_data;

  dma_fifo #(.WIDTH(32), .DEPTH(4)) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (f_in_valid),
    .o_in_ready  (f_in_ready),
    .i_in_data   (i_bus_rdata),
    .o_out_valid (f_out_valid),
    .i_out_ready (f_out_ready),
    .o_out_data  (f_out_data)
  );

  // Engine next state; addresses must already be aligned, none is fixed up here
  always_comb begin
    logic [31:0] cfg, nbyte;
    logic [2:0]  nbeat;
    logic [MAJ_W-1:0] cdec, half;
    logic        found;
    logic [CW-1:0] k, win;
    logic [PW-1:0] best;
    logic        bwc;
    desc_next = desc_reg;
    major_count_current_next = major_count_current_reg;
    pend_next = pend_reg;
    done_next = done_reg;
    irqm_next = '0;
    irqh_next = '0;
    state_next = state_reg;
    ret_next = ret_reg;
    ch_next = ch_reg;
    last_next = last_reg;
    beat_next = beat_reg;
    left_next = left_reg;
    stall_next = stall_reg;
    req_next = req_reg;
    we_next = we_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    size_next = size_reg;
    f_in_valid = 1'b0;
    f_out_ready = 1'b0;
    cfg = desc_reg[ch_reg][W_CFG];
    nbyte = size_bytes(cfg[CFG_SSZ_LSB +: 2]);
    nbeat = (cfg[CFG_SSZ_LSB +: 2] == SZ_128) ? 3'h4 : 3'h1;
    bwc = cfg[CFG_BWC_EN];
    cdec = major_count_current_reg[ch_reg] - 1'b1;
    half = desc_reg[ch_reg][W_CFG][CFG_MAJ_LSB +: MAJ_W] >> 1;
    found = 1'b0;
    win = '0;
    best = '0;
    k = '0;
    // Arbitration over pending channels
    for (int i = 0; i < NUM_CH; i++) begin
      k = i_arb_rr ? CW'(32'(last_reg) + 1 + i) : CW'(i);
      if (pend_reg[k] && (!found || (!i_arb_rr && i_prio[k*PW +: PW] > best))) begin
        found = 1'b1;
        win = k;
        best = i_prio[k*PW +: PW];
      end
    end
    // Peripheral requests; set beats the clear below
    pend_next = pend_reg | i_req;
    case (state_reg)
      S_IDLE: begin
        if (found) begin
          pend_next[win] = i_req[win];
          ch_next = win;
          last_next = win;
          done_next[win] = 1'b0;
          left_next = desc_reg[win][W_NBYTE];
          beat_next = '0;
          state_next = S_RD;
        end
      end
      S_RD: begin
        if (!req_reg && f_in_ready) begin
          req_next = 1'b1;
          we_next = 1'b0;
          addr_next = desc_reg[ch_reg][W_SADDR] + {27'h0, beat_reg, 2'h0};
          size_next = (nbeat == 3'h4) ? SZ_32 : cfg[CFG_SSZ_LSB +: 2];
        end else if (req_reg && i_bus_ack) begin
          req_next = 1'b0;
          f_in_valid = 1'b1;
          beat_next = beat_reg + 1'b1;
          if (beat_reg == nbeat - 1'b1) begin
            beat_next = '0;
            desc_next[ch_reg][W_SADDR] = step(desc_reg[ch_reg][W_SADDR],
              desc_reg[ch_reg][W_SOFF], cfg[CFG_SMOD_LSB +: 4]);
            state_next = bwc ? S_STALL : S_WR;
            ret_next = S_WR;
            stall_next = cfg[CFG_BWC_8] ? BWC_LONG : BWC_SHORT;
          end
        end
      end
      S_WR: begin
        if (!req_reg && f_out_valid) begin
          f_out_ready = 1'b1;
          req_next = 1'b1;
          we_next = 1'b1;
          wdata_next = f_out_data;
          addr_next = desc_reg[ch_reg][W_DADDR] + {27'h0, beat_reg, 2'h0};
          size_next = (nbeat == 3'h4) ? SZ_32 : cfg[CFG_SSZ_LSB +: 2];
        end else if (req_reg && i_bus_ack) begin
          req_next = 1'b0;
          we_next = 1'b0;
          beat_next = beat_reg + 1'b1;
          if (beat_reg == nbeat - 1'b1) begin
            beat_next = '0;
            desc_next[ch_reg][W_DADDR] = step(desc_reg[ch_reg][W_DADDR],
              desc_reg[ch_reg][W_DOFF], cfg[CFG_DMOD_LSB +: 4]);
            left_next = left_reg - nbyte;
            ret_next = (left_reg <= nbyte) ? S_PASS : S_RD;
            state_next = bwc ? S_STALL : ret_next;
            stall_next = cfg[CFG_BWC_8] ? BWC_LONG : BWC_SHORT;
          end
        end
      end
      S_STALL: begin
        stall_next = stall_reg - 1'b1;
        if (stall_reg == 4'h1) state_next = ret_reg;
      end
      S_PASS: begin
        major_count_current_next[ch_reg] = cdec;
        state_next = S_IDLE;
        if (cfg[CFG_INT_HALF] && cdec == half && half != RST_MAJ) irqh_next[ch_reg] = 1'b1;
        if (cdec == RST_MAJ) begin
          major_count_current_next[ch_reg] = cfg[CFG_MAJ_LSB +: MAJ_W];
          done_next[ch_reg] = 1'b1;
          irqm_next[ch_reg] = cfg[CFG_INT_MAJ];
          desc_next[ch_reg][W_SADDR] = desc_reg[ch_reg][W_SADDR] + desc_reg[ch_reg][W_SLAST];
          if (i_link_major_en[ch_reg]) pend_next[i_link_major_ch[ch_reg*CW +: CW]] = 1'b1;
          if (i_sg_en[ch_reg]) begin
            state_next = S_SG;
            beat_next = '0;
          end else begin
            desc_next[ch_reg][W_DADDR] = desc_reg[ch_reg][W_DADDR] + desc_reg[ch_reg][W_DLAST];
          end
        end else if (i_link_minor_en[ch_reg]) begin
          pend_next[i_link_minor_ch[ch_reg*CW +: CW]] = 1'b1;
        end
      end
      S_SG: begin
        // Last word holds the next descriptor address while chaining
        if (!req_reg) begin
          req_next = 1'b1;
          we_next = 1'b0;
          size_next = SZ_32;
          addr_next = desc_reg[ch_reg][W_DLAST] + {27'h0, beat_reg, 2'h0};
        end else if (i_bus_ack) begin
          req_next = 1'b0;
          desc_next[ch_reg][beat_reg] = i_bus_rdata;
          beat_next = beat_reg + 1'b1;
          if (beat_reg == 3'h7) begin
            major_count_current_next[ch_reg] = i_bus_rdata[CFG_MAJ_LSB +: MAJ_W];
            if (beat_reg != W_CFG) major_count_current_next[ch_reg] = desc_reg[ch_reg][W_CFG][CFG_MAJ_LSB +: MAJ_W];
            state_next = S_IDLE;
          end
        end
      end
      default: state_next = S_IDLE;
    endcase
    // Software load; a config write also restarts the current count
    if (i_desc_wr) begin
      desc_next[i_desc_ch][i_desc_idx] = i_desc_data;
      if (i_desc_idx == W_CFG) major_count_current_next[i_desc_ch] = i_desc_data[CFG_MAJ_LSB +: MAJ_W];
    end
    // Busy tracks the state being entered, so the port needs no decode after the flop
    busy_next = state_next != S_IDLE;
  end

  // Registers only
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      for (int c = 0; c < NUM_CH; c++) begin
        major_count_current_reg[c] <= RST_MAJ;
        for (int w = 0; w < DESC_WORDS; w++) desc_reg[c][w] <= RST_WORD;
      end
      pend_reg <= '0;
      done_reg <= '0;
      irqm_reg <= '0;
      irqh_reg <= '0;
      state_reg <= S_IDLE;
      ret_reg <= S_IDLE;
      ch_reg <= '0;
      last_reg <= '0;
      beat_reg <= '0;
      left_reg <= RST_WORD;
      stall_reg <= '0;
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      addr_reg <= RST_WORD;
      wdata_reg <= RST_WORD;
      size_reg <= SZ_8;
      busy_reg <= 1'b0;
    end else begin
      desc_reg <= desc_next;
      major_count_current_reg <= major_count_current_next;
      pend_reg <= pend_next;
      done_reg <= done_next;
      irqm_reg <= irqm_next;
      irqh_reg <= irqh_next;
      state_reg <= state_next;
      ret_reg <= ret_next;
      ch_reg <= ch_next;
      last_reg <= last_next;
      beat_reg <= beat_next;
      left_reg <= left_next;
      stall_reg <= stall_next;
      req_reg <= req_next;
      we_reg <= we_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      size_reg <= size_next;
      busy_reg <= busy_next;
    end
  end

  // Outputs straight from flops
  assign o_bus_req = req_reg;
  assign o_bus_we = we_reg;
  assign o_bus_addr = addr_reg;
  assign o_bus_size = size_reg;
  assign o_bus_wdata = wdata_reg;
  assign o_done = done_reg;
  assign o_irq_major = irqm_reg;
  assign o_irq_half = irqh_reg;
  assign o_busy = busy_reg;
  assign o_active_ch = ch_reg;
endmodule : dma_engine
`default_nettype wire

// ---- design/dma_pkg.sv ----
// Function
// - No auto alignment; addresses and minor count must match transfer size
// - Arbitration is fixed priority or round robin; per-channel priority
// - Each channel holds a 32-bit minor byte count
// - Each channel holds a 14-bit major loop count
// - Bandwidth control stalls 4 or 8 cycles after every read or write element; a 128-bit element stalls once, after its fourth beat
// - Addresses step by own signed 32-bit offset after each element; a 128-bit element steps once, after its fourth beat
// - Signed last adjustment added to source address at major end, and to destination address unless scatter/gather is on
// - Modulo window freezes upper address bits for circular buffers
// - Scatter/gather loads next descriptor from memory at transfer end
// - Minor loop end may raise request of a linked channel
// - Major loop end may raise request of a linked channel
// - Completion interrupt when current major count reaches zero
// - Half interrupt when current major count falls to half of start
// - Each inner pass needs its own service request
// - Transfer attributes are held in a 32 byte descriptor
// - Start and current major counts are kept separately
// - Transfer sizes 8, 16, 32 or 128 bits per element
package dma_pkg;
  // Descriptor word indices, eight words of 32 bits
  localparam int DESC_WORDS = 8;
  localparam logic [2:0] W_SADDR = 3'h0;
  localparam logic [2:0] W_SOFF  = 3'h1;
  localparam logic [2:0] W_NBYTE = 3'h2;
  localparam logic [2:0] W_SLAST = 3'h3;
  localparam logic [2:0] W_DADDR = 3'h4;
  localparam logic [2:0] W_DOFF  = 3'h5;
  localparam logic [2:0] W_CFG   = 3'h6;
  localparam logic [2:0] W_DLAST = 3'h7;
  // Configuration word fields
  localparam int CFG_MAJ_LSB  = 0;
  localparam int MAJ_W        = 14;
  localparam int CFG_SSZ_LSB  = 16;
  localparam int CFG_SMOD_LSB = 20;
  localparam int CFG_DMOD_LSB = 24;
  localparam int CFG_INT_MAJ  = 28;
  localparam int CFG_INT_HALF = 29;
  localparam int CFG_BWC_EN   = 30;
  localparam int CFG_BWC_8    = 31;
  // Size codes
  localparam logic [1:0] SZ_8   = 2'h0;
  localparam logic [1:0] SZ_16  = 2'h1;
  localparam logic [1:0] SZ_32  = 2'h2;
  localparam logic [1:0] SZ_128 = 2'h3;
  // Stall lengths in cycles
  localparam logic [3:0] BWC_SHORT = 4'h4;
  localparam logic [3:0] BWC_LONG  = 4'h8;
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0;
  localparam logic [MAJ_W-1:0] RST_MAJ = 14'h0;
  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_RD    = 6'h02,
    S_WR    = 6'h04,
    S_STALL = 6'h08,
    S_PASS  = 6'h10,
    S_SG    = 6'h20
  } state_t;
endpackage : dma_pkg

// ---- design/dma_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module dma_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_sys_rst,
  // Fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;
  // Pointer and count update
  always_comb begin
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    wp_next = push ? AW'((wp_reg + 1'b1) % DEPTH) : wp_reg;
    rp_next = pop ? AW'((rp_reg + 1'b1) % DEPTH) : rp_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
    end
  end
  // Storage needs no reset, guarded by count
  always_ff @(posedge i_ref_clk) begin
    if (push) mem_reg[wp_reg] <= i_in_data;
  end
  assign o_in_ready = cnt_reg != (AW+1)'(DEPTH);
  assign o_out_valid = cnt_reg != '0;
  assign o_out_data = mem_reg[rp_reg];
endmodule : dma_fifo
`default_nettype wire

// ---- testbench/dma_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module dma_checker #(
  parameter int NUM_CH = 16
) (
  // Clock and reset
  input wire logic              i_ref_clk,
  input wire logic              i_sys_rst,
  // Bus master side
  input wire logic              o_bus_req,
  input wire logic              o_bus_we,
  input wire logic [31:0]       o_bus_addr,
  input wire logic [1:0]        o_bus_size,
  input wire logic [31:0]       o_bus_wdata,
  input wire logic              i_bus_ack,
  // Status
  input wire logic [NUM_CH-1:0] o_done,
  input wire logic [NUM_CH-1:0] o_irq_major,
  input wire logic [NUM_CH-1:0] o_irq_half,
  input wire logic              o_busy
);
  import dma_pkg::*;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // Handshake: request and its qualifiers hold until ack
  req_hold_a: assert property (o_bus_req && !i_bus_ack |=> o_bus_req && $stable(o_bus_addr)
    && $stable(o_bus_we) && $stable(o_bus_size) && $stable(o_bus_wdata)) else $error("bus request moved");
  req_drop_a: assert property (o_bus_req && i_bus_ack |=> !o_bus_req)
    else $error("request held after ack");
  pass_start_a: assert property ($rose(o_busy) |=> o_bus_req && !o_bus_we)
    else $error("pass did not open with a read");
  req_busy_a: assert property (o_bus_req |-> o_busy)
    else $error("request while idle");
  // Wide transfers go out as word beats, never as a 128-bit code
  size_code_a: assert property (o_bus_req |-> o_bus_size != SZ_128)
    else $error("illegal bus size code");
  word_align_a: assert property (o_bus_req && o_bus_size == SZ_32 |-> o_bus_addr[1:0] == 2'h0)
    else $error("word access misaligned");
  irq_pulse_a: assert property ((o_irq_major & $past(o_irq_major)) == '0)
    else $error("major irq longer than a cycle");
  irq_done_a: assert property ((o_irq_major & ~o_done) == '0)
    else $error("major irq without done");
  half_apart_a: assert property ((o_irq_half & o_irq_major) == '0)
    else $error("half and major irq together");
  // Main scenarios reached
  cover property ($rose(o_busy));
  cover property (|o_irq_half);
  cover property (o_bus_req && o_bus_we && i_bus_ack);
endmodule : dma_checker
bind dma_engine dma_checker #(.NUM_CH(NUM_CH)) i_chk (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
  .o_bus_req(o_bus_req), .o_bus_we(o_bus_we), .o_bus_addr(o_bus_addr), .o_bus_size(o_bus_size),
  .o_bus_wdata(o_bus_wdata), .i_bus_ack(i_bus_ack), .o_done(o_done), .o_irq_major(o_irq_major),
  .o_irq_half(o_irq_half), .o_busy(o_busy));
`default_nettype wire

// ---- testbench/mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  // Clock and bus from engine
  input wire logic        i_ref_clk,
  input wire logic        i_req,
  input wire logic        i_we,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  // Wait states before ack
  input wire logic [1:0]  i_wait,
  output logic            o_ack,
  output logic [31:0]     o_rdata
);
  logic [31:0] mem [64];
  logic [1:0]  cnt;
  initial begin
    o_ack = 1'b0;
    o_rdata = 32'h0;
    cnt = 2'h0;
  end
  // Read data toggles outside ack so stale data is never trusted
  always @(posedge i_ref_clk) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req && !o_ack) begin
      if (cnt == i_wait) begin
        o_ack <= 1'b1;
        cnt <= 2'h0;
        if (i_we) mem[i_addr[7:2]] <= i_wdata;
        else o_rdata <= mem[i_addr[7:2]];
      end else cnt <= cnt + 2'h1;
    end
  end
endmodule : mem_model
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk, rst, rr, dwr, breq, bwe, ack, busy;
  logic [3:0]  req, sg, lmin, lmaj, done, irqm, irqh;
  logic [15:0] prio;
  logic [7:0]  lminc, lmajc;
  logic [1:0]  dch, bsz, wt, act;
  logic [2:0]  didx;
  logic [31:0] ddat, baddr, bwd, brd;
  logic [31:0] rq[$], wq[$];
  logic        ow[$];
  int          bad_count, samples_checked, cyc, nh, nm, aq[$];
  dma_engine #(.NUM_CH(4)) i_dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_req(req), .i_arb_rr(rr),
    .i_prio(prio), .i_sg_en(sg), .i_link_minor_en(lmin), .i_link_minor_ch(lminc), .i_link_major_en(lmaj),
    .i_link_major_ch(lmajc), .i_desc_wr(dwr), .i_desc_ch(dch), .i_desc_idx(didx), .i_desc_data(ddat),
    .o_bus_req(breq), .o_bus_we(bwe), .o_bus_addr(baddr), .o_bus_size(bsz), .o_bus_wdata(bwd),
    .i_bus_ack(ack), .i_bus_rdata(brd), .o_done(done), .o_irq_major(irqm), .o_irq_half(irqh),
    .o_busy(busy), .o_active_ch(act));
  mem_model i_mem (.i_ref_clk(clk), .i_req(breq), .i_we(bwe), .i_addr(baddr), .i_wdata(bwd),
    .i_wait(wt), .o_ack(ack), .o_rdata(brd));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Log of completed accesses and irq pulses
  always @(posedge clk) begin
    cyc++;
    nh += $countones(irqh);
    nm += $countones(irqm);
    if (breq && ack) begin
      aq.push_back(cyc);
      ow.push_back(bwe);
      if (bwe) wq.push_back(baddr);
      else rq.push_back(baddr);
    end
  end
  task automatic chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wd(input logic [1:0] c, input logic [2:0] i, input logic [31:0] v);
    @(negedge clk);
    {dwr, dch, didx, ddat} = {1'b1, c, i, v};
    @(negedge clk);
    dwr = 1'b0;
  endtask : wd
  task automatic prog(input logic [1:0] c, input logic [31:0] s, n, d, cf, w7);
    logic [31:0] v [8];
    v = '{s, 32'h4, n, 32'h0, d, 32'h4, cf, w7};
    for (int k = 0; k < 8; k++) wd(c, 3'(k), v[k]);
  endtask : prog
  task automatic kick(input logic [3:0] m);
    @(negedge clk);
    req = m;
    @(negedge clk);
    req = 4'h0;
  endtask : kick
  // Idle long enough that no pending pass can still start
  task automatic settle();
    int q;
    q = 0;
    for (int i = 0; i < 3000 && q < 12; i++) begin
      @(negedge clk);
      q = (busy === 1'b0) ? q + 1 : 0;
    end
  endtask : settle
  task automatic t_copy();
    prog(2'h0, 32'h0, 32'h8, 32'h40, 32'h3002_0002, 32'h0);
    wd(2'h0, 3'h3, 32'hffff_fff0);
    nh = 0;
    nm = 0;
    kick(4'h1); settle();
    chk(nh, 1);
    kick(4'h1); settle();
    chk(nm, 1);
    chk(done[0], 1);
    for (int k = 0; k < 4; k++) chk(i_mem.mem[16+k], i_mem.mem[k]);
    rq.delete();
    kick(4'h1); settle();
    chk(rq[0], 32'h0);
    chk(nh, 2);
    $display("copy test done");
  endtask : t_copy
  task automatic t_bwc();
    logic [31:0] bw [3] = '{32'h0, 32'h4000_0000, 32'hc000_0000};
    int g [3];
    for (int k = 0; k < 3; k++) begin
      prog(2'h1, 32'h0, 32'h4, 32'h70, 32'h0002_0001 | bw[k], 32'h0);
      kick(4'h2); settle();
      g[k] = aq[$] - aq[$-1];
    end
    chk(g[1] - g[0], 4);
    chk(g[2] - g[0], 8);
    $display("stall test done");
  endtask : t_bwc
  task automatic t_mod();
    prog(2'h2, 32'h0, 32'h10, 32'h80, 32'h0302_0001, 32'h0);
    wq.delete();
    kick(4'h4); settle();
    for (int k = 0; k < 4; k++) chk(wq[k], k[0] ? 32'h84 : 32'h80);
    $display("modulo test done");
  endtask : t_mod
  task automatic t_link();
    prog(2'h0, 32'h0, 32'h4, 32'h90, 32'h0002_0002, 32'h0);
    prog(2'h1, 32'h0, 32'h4, 32'h94, 32'h0002_0001, 32'h0);
    prog(2'h3, 32'h0, 32'h4, 32'h98, 32'h0002_0001, 32'h0);
    @(negedge clk);
    {lmin, lminc, lmaj, lmajc, wt} = {4'h1, 8'h01, 4'h1, 8'h03, 2'h2};
    wq.delete();
    kick(4'h1); settle();
    chk(wq.size(), 2);
    chk(done[3], 0);
    wq.delete();
    kick(4'h1); settle();
    chk(wq.size(), 2);
    chk(wq[1], 32'h98);
    chk(done[3], 1);
    chk(act, 3);
    @(negedge clk);
    {lmin, lmaj, wt} = 10'h0;
    $display("link test done");
  endtask : t_link
  task automatic t_arb();
    logic [15:0] p [4] = '{16'h5020, 16'h2070, 16'hf000, 16'hf000};
    logic [3:0]  m [4] = '{4'ha, 4'ha, 4'h9, 4'ha};
    logic [31:0] e [4] = '{32'h30, 32'h10, 32'h0, 32'h10};
    for (int c = 0; c < 4; c += (c == 1) ? 2 : 1) begin
      prog(2'(c), 32'(c * 16), 32'h4, 32'hb0, 32'h0002_0001, 32'h0);
      wd(2'(c), 3'h3, 32'hffff_fffc);
    end
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      rr = k[1];
      prio = p[k];
      rq.delete();
      kick(m[k]); settle();
      chk(rq[0], e[k]);
    end
    $display("arbitration test done");
  endtask : t_arb
  task automatic t_sg();
    logic [31:0] v [8] = '{32'h0, 32'h4, 32'h4, 32'h0, 32'ha0, 32'h4, 32'h0002_0001, 32'h0};
    for (int k = 0; k < 8; k++) i_mem.mem[48+k] = v[k];
    prog(2'h2, 32'h4, 32'h4, 32'hbc, 32'h0002_0001, 32'hc0);
    @(negedge clk);
    sg = 4'h4;
    rq.delete();
    kick(4'h4); settle();
    chk(rq.size(), 9);
    chk(rq[1], 32'hc0);
    chk(rq[8], 32'hdc);
    kick(4'h4); settle();
    chk(i_mem.mem[40], i_mem.mem[0]);
    sg = 4'h0;
    $display("chain test done");
  endtask : t_sg
  task automatic t_wide();
    prog(2'h1, 32'h0, 32'h10, 32'h60, 32'h0003_0001, 32'h0);
    wd(2'h1, 3'h1, 32'h10);
    wd(2'h1, 3'h5, 32'h10);
    wq.delete();
    kick(4'h2); settle();
    for (int k = 0; k < 4; k++) chk(i_mem.mem[24+k], i_mem.mem[k]);
    chk(wq[3], 32'h6c);
    chk(bsz, dma_pkg::SZ_32);
    // Narrow codes: element count follows the byte width of the code
    prog(2'h1, 32'h1, 32'h2, 32'h60, 32'h0000_0001, 32'h0);
    rq.delete();
    kick(4'h2); settle();
    chk(rq.size(), 2);
    chk(rq[1], 32'h5);
    chk(bsz, dma_pkg::SZ_8);
    prog(2'h1, 32'h2, 32'h4, 32'h60, 32'h0001_0001, 32'h0);
    rq.delete();
    kick(4'h2); settle();
    chk(rq.size(), 2);
    chk(rq[1], 32'h6);
    chk(bsz, dma_pkg::SZ_16);
    $display("wide test done");
  endtask : t_wide
  // Wide pass with wait states: the buffer must absorb all four read beats before any write
  task automatic t_fifo();
    prog(2'h3, 32'h10, 32'h10, 32'h70, 32'h0003_0001, 32'h0);
    @(negedge clk);
    wt = 2'h1;
    rq.delete();
    wq.delete();
    ow.delete();
    kick(4'h8); settle();
    chk(rq.size(), 4);
    chk(wq.size(), 4);
    chk({ow[0], ow[3], ow[4], ow[7]}, 4'h3);
    chk(rq[3], 32'h1c);
    for (int k = 0; k < 4; k++) chk(i_mem.mem[28+k], i_mem.mem[4+k]);
    wt = 2'h0;
    $display("buffer test done");
  endtask : t_fifo
  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  initial begin
    {rst, rr, dwr, req, sg, lmin, lmaj, prio, lminc, lmajc} = {3'h4, 32'h0, 16'h0};
    {dch, didx, ddat, wt} = 39'h0;
    for (int k = 0; k < 64; k++) i_mem.mem[k] = {24'ha5c3e1, 8'(k)};
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_copy();
    t_bwc();
    t_mod();
    t_link();
    t_arb();
    t_sg();
    t_wide();
    t_fifo();
    close_out();
  end
  // Watchdog well beyond the expected thousand or so cycles
  initial begin
    #(40000 * 50);
    bad_count++;
    close_out();
  end
endmodule : tb
`default_nettype wire
